// ===== core/cfg_access_defines.svh
// constants for the configuration-register access controller
// assumes a 25 MHz clock (40 ns) and a single driver of the memory bus
//
// How it works
// - register load is read, read, write, write, all at one address
// - register read is read, read, write, read; the fourth access, a read, returns the value
// - every sequence operation targets the top word address of the part
// - value travels on data bus: host drives writes, device drives final read
// - chip select stays high at least 150 ns before the register read
// - host never enables deep sleep by the sequence; a sequence load with bit 4 set can still disable it
// - host keeps the low-power entry pin under its own control
// - host accepts code 0 (on-chip sensor) or a fixed threshold not below the software floor
// - pin load: write right after low-power pin falls, address is the value
// - partial refresh starts after pin held low over 10 us, bit 4 set
`ifndef CFG_ACCESS_DEFINES_SVH
`define CFG_ACCESS_DEFINES_SVH

`define REG_CTRL        5'h00
`define REG_CFG_VALUE   5'h04
`define REG_STATUS      5'h08
`define REG_READBACK    5'h0c
`define REG_TEMP_FLOOR  5'h10

`define CMD_SW_LOAD     0
`define CMD_SW_READ     1
`define CMD_PIN_LOAD    2
`define CMD_SLEEP_IN    3
`define CMD_SLEEP_OUT   4

`define CFG_RESET       16'h0010
`define CFG_SLEEP_BIT   4
`define CFG_TCR_LO      5
`define CFG_TCR_HI      6

`define TCR_15C         2'h1
`define TCR_45C         2'h2
`define TCR_85C         2'h3

`define CLK_NS          40
`define T_ACC_NS        70
`define T_CEH_NS        150
`define T_ZZ_NS         10000
`define T_INIT_NS       150000
`define CYC_ACC         ((`T_ACC_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_CEH         ((`T_CEH_NS + `CLK_NS - 1) / `CLK_NS)
`define CYC_ZZ          (`T_ZZ_NS / `CLK_NS + 1)
`define CYC_INIT        ((`T_INIT_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// ===== core/cfg_access_pkg.sv
// types shared by the configuration-register access controller
// assumes nothing beyond the constants header
package cfg_access_pkg;
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_GAP    = 3'b001,
      ST_OP     = 3'b010,
      ST_ZZ_SET = 3'b011,
      ST_SLEEP  = 3'b100,
      ST_WAKE   = 3'b101
   } state_e;

   typedef enum logic [1:0] {
      JOB_SW_LOAD  = 2'h0,
      JOB_SW_READ  = 2'h1,
      JOB_PIN_LOAD = 2'h2
   } job_e;

   typedef struct packed {
      logic        ce_n;
      logic        we_n;
      logic        oe_n;
      logic        lower_byte_enable_n;
      logic        upper_byte_enable_n;
      logic        low_power_entry_n;
      logic [20:0] addr;
      logic [15:0] dq_o;
      logic        dq_oe;
   } mem_pins_s;
endpackage

// ===== core/cfg_access_host.sv
// host controller for config-register access and low-power entry
// assumes it alone drives the memory pins; dq_i is synchronous to clk
`timescale 1ns/10ps
`default_nettype none
`include "cfg_access_defines.svh"

module cfg_access_host #(
   parameter int ADDR_W = 21
) (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic [4:0]              addr,
   input  wire logic [31:0]             wdata,
   input  wire logic                    wr,
   input  wire logic                    rd,
   output logic [31:0]                  rdata,
   output cfg_access_pkg::mem_pins_s    pins,
   input  wire logic [15:0]             dq_i
);

   if (ADDR_W != 20 && ADDR_W != 21) begin : g_bad_addr_w
      $error("ADDR_W must be 20 or 21");
   end

   localparam logic [20:0] TOP_ADDR = 21'((64'h1 << ADDR_W) - 64'h1);
   localparam logic [12:0] N_ACC  = 13'(`CYC_ACC);
   localparam logic [12:0] N_CEH  = 13'(`CYC_CEH);
   localparam logic [12:0] N_ZZ   = 13'(`CYC_ZZ);
   localparam logic [12:0] N_INIT = 13'(`CYC_INIT);

   cfg_access_pkg::state_e state_r;
   cfg_access_pkg::job_e   job_r;
   logic [12:0] cnt_r;
   logic [1:0]  op_r;
   logic [15:0] cfg_val_r;
   logic [15:0] shadow_r;
   logic [15:0] readback_r;
   logic [1:0]  floor_r;
   logic        sw_loaded_r;
   logic        err_r;
   logic        par_on_r;
   logic        dpd_on_r;
   logic        busy;
   logic        cmd;
   logic [15:0] new_cfg;

   ////////////////////////////////////////////////////////////////////////
   // fixed-rate threshold must not fall below the floor software set
   function automatic logic tcr_ok(input logic [1:0] code, input logic [1:0] floor);
      tcr_ok = (code == 2'h0) || (code >= floor);
   endfunction

   assign busy    = (state_r != cfg_access_pkg::ST_IDLE);
   assign cmd     = wr && (addr == `REG_CTRL) && !busy && (state_r != cfg_access_pkg::ST_SLEEP);
   assign new_cfg = cfg_val_r;

   ////////////////////////////////////////////////////////////////////////
   // software-side registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_val_r <= `CFG_RESET;
         floor_r   <= 2'h0;
      end else if (wr && addr == `REG_CFG_VALUE) begin
         cfg_val_r <= wdata[15:0];
      end else if (wr && addr == `REG_TEMP_FLOOR) begin
         floor_r   <= wdata[1:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata <= 32'h0;
      end else if (rd) begin
         case (addr)
            `REG_CFG_VALUE:  rdata <= {16'h0, cfg_val_r};
            `REG_STATUS:     rdata <= {26'h0, dpd_on_r, par_on_r, sw_loaded_r, err_r, busy,
                                       state_r == cfg_access_pkg::ST_SLEEP};
            `REG_READBACK:   rdata <= {readback_r, shadow_r};
            `REG_TEMP_FLOOR: rdata <= {30'h0, floor_r};
            default:         rdata <= 32'h0;
         endcase
      end else begin
         rdata <= 32'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // sequencer; sequences run back to back, no other access slips in
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= cfg_access_pkg::ST_IDLE;
         job_r   <= cfg_access_pkg::JOB_SW_LOAD;
         cnt_r   <= 13'h0;
         op_r    <= 2'h0;
         pins    <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, lower_byte_enable_n: 1'b1,
                      upper_byte_enable_n: 1'b1, low_power_entry_n: 1'b1, addr: 21'h0,
                      dq_o: 16'h0, dq_oe: 1'b0};
      end else begin
         case (state_r)
            cfg_access_pkg::ST_IDLE: begin
               if (cmd && wdata[`CMD_SW_LOAD] && new_cfg[`CFG_SLEEP_BIT]
                   && tcr_ok(new_cfg[`CFG_TCR_HI:`CFG_TCR_LO], floor_r)) begin
                  job_r   <= cfg_access_pkg::JOB_SW_LOAD;
                  op_r    <= 2'h0;
                  cnt_r   <= N_CEH - 13'h1;
                  state_r <= cfg_access_pkg::ST_GAP;
               end else if (cmd && wdata[`CMD_SW_READ]) begin
                  job_r   <= cfg_access_pkg::JOB_SW_READ;
                  op_r    <= 2'h0;
                  cnt_r   <= N_CEH - 13'h1;
                  state_r <= cfg_access_pkg::ST_GAP;
               end else if (cmd && wdata[`CMD_PIN_LOAD]
                            && tcr_ok(new_cfg[`CFG_TCR_HI:`CFG_TCR_LO], floor_r)) begin
                  job_r   <= cfg_access_pkg::JOB_PIN_LOAD;
                  op_r    <= 2'h3;
                  pins.low_power_entry_n <= 1'b0;
                  state_r <= cfg_access_pkg::ST_ZZ_SET;
               end else if (cmd && wdata[`CMD_SLEEP_IN]) begin
                  cnt_r   <= 13'h0;
                  pins.low_power_entry_n <= 1'b0;
                  state_r <= cfg_access_pkg::ST_SLEEP;
               end
            end
            cfg_access_pkg::ST_ZZ_SET: begin
               cnt_r   <= N_CEH - 13'h1;
               state_r <= cfg_access_pkg::ST_GAP;
            end
            cfg_access_pkg::ST_GAP: begin
               // chip select high long enough before every op, including the read
               if (cnt_r == 13'h0) begin
                  pins.ce_n  <= 1'b0;
                  pins.addr  <= (job_r == cfg_access_pkg::JOB_PIN_LOAD) ?
                                21'(new_cfg) : TOP_ADDR;
                  pins.lower_byte_enable_n <= 1'b0;
                  pins.upper_byte_enable_n <= 1'b0;
                  if (op_r < 2'h2 || (op_r == 2'h3 && job_r == cfg_access_pkg::JOB_SW_READ)) begin
                     pins.oe_n <= 1'b0;
                  end else begin
                     pins.we_n  <= 1'b0;
                     pins.dq_o  <= new_cfg;
                     pins.dq_oe <= 1'b1;
                  end
                  cnt_r   <= N_ACC - 13'h1;
                  state_r <= cfg_access_pkg::ST_OP;
               end else begin
                  cnt_r <= cnt_r - 13'h1;
               end
            end
            cfg_access_pkg::ST_OP: begin
               if (cnt_r == 13'h0) begin
                  pins.ce_n  <= 1'b1;
                  pins.we_n  <= 1'b1;
                  pins.oe_n  <= 1'b1;
                  pins.dq_oe <= 1'b0;
                  pins.lower_byte_enable_n <= 1'b1;
                  pins.upper_byte_enable_n <= 1'b1;
                  if (op_r == 2'h3) begin
                     pins.low_power_entry_n <= 1'b1;
                     state_r <= cfg_access_pkg::ST_IDLE;
                  end else begin
                     op_r    <= op_r + 2'h1;
                     cnt_r   <= N_CEH - 13'h1;
                     state_r <= cfg_access_pkg::ST_GAP;
                  end
               end else begin
                  cnt_r <= cnt_r - 13'h1;
               end
            end
            cfg_access_pkg::ST_SLEEP: begin
               if (cnt_r != 13'h1fff) begin
                  cnt_r <= cnt_r + 13'h1;
               end
               if (wr && addr == `REG_CTRL && wdata[`CMD_SLEEP_OUT]) begin
                  pins.low_power_entry_n <= 1'b1;
                  cnt_r   <= N_INIT - 13'h1;
                  // deep sleep exit costs the full initialisation wait
                  state_r <= dpd_on_r ? cfg_access_pkg::ST_WAKE : cfg_access_pkg::ST_IDLE;
               end
            end
            cfg_access_pkg::ST_WAKE: begin
               if (cnt_r == 13'h0) begin
                  state_r <= cfg_access_pkg::ST_IDLE;
               end else begin
                  cnt_r <= cnt_r - 13'h1;
               end
            end
            default: state_r <= cfg_access_pkg::ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // host view of the device register and its low-power state
   logic op_end;
   assign op_end = (state_r == cfg_access_pkg::ST_OP) && (cnt_r == 13'h0) && (op_r == 2'h3);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         shadow_r    <= `CFG_RESET;
         readback_r  <= 16'h0;
         sw_loaded_r <= 1'b0;
      end else if (op_end) begin
         if (job_r == cfg_access_pkg::JOB_SW_READ) begin
            readback_r <= dq_i;
            shadow_r   <= dq_i;
         end else begin
            shadow_r   <= new_cfg;
         end
         if (job_r == cfg_access_pkg::JOB_SW_LOAD) begin
            sw_loaded_r <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         err_r <= 1'b0;
      end else if (cmd && ((wdata[`CMD_SW_LOAD] && !new_cfg[`CFG_SLEEP_BIT])
                           || !tcr_ok(new_cfg[`CFG_TCR_HI:`CFG_TCR_LO], floor_r))) begin
         err_r <= 1'b1;
      end else if (cmd) begin
         err_r <= 1'b0;
      end
   end

   // partial refresh: immediate after a sequence load, else by a long pin low
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         par_on_r <= 1'b0;
         dpd_on_r <= 1'b0;
      end else begin
         par_on_r <= sw_loaded_r ? shadow_r[`CFG_SLEEP_BIT] :
                     (state_r == cfg_access_pkg::ST_SLEEP && cnt_r >= N_ZZ
                      && shadow_r[`CFG_SLEEP_BIT]);
         dpd_on_r <= (state_r == cfg_access_pkg::ST_SLEEP) && (cnt_r >= N_ZZ)
                     && !shadow_r[`CFG_SLEEP_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   logic seq_r;
   assign seq_r = (job_r != cfg_access_pkg::JOB_PIN_LOAD) &&
                  (state_r == cfg_access_pkg::ST_OP || state_r == cfg_access_pkg::ST_GAP);

   a_seq_top_addr: assert property (@(posedge clk) disable iff (!rst_n)
      (!pins.ce_n && seq_r) |-> pins.addr == TOP_ADDR) else $error("sequence not at top address");
   a_ceh_before_op: assert property (@(posedge clk) disable iff (!rst_n)
      $fell(pins.ce_n) |-> $past(pins.ce_n, 1) && $past(pins.ce_n, 2) && $past(pins.ce_n, 3)
                           && $past(pins.ce_n, 4)) else $error("chip select high too short");
   a_reads_first: assert property (@(posedge clk) disable iff (!rst_n)
      (!pins.ce_n && seq_r && op_r < 2'h2) |-> pins.we_n && !pins.oe_n) else $error("first ops not reads");
   a_write_drives_dq: assert property (@(posedge clk) disable iff (!rst_n)
      (!pins.ce_n && !pins.we_n) |-> pins.dq_oe && pins.dq_o == new_cfg) else $error("write without data");
   a_read_no_drive: assert property (@(posedge clk) disable iff (!rst_n)
      !pins.oe_n |-> !pins.dq_oe) else $error("bus fight on read");
   a_pin_write_zz: assert property (@(posedge clk) disable iff (!rst_n)
      (!pins.we_n && job_r == cfg_access_pkg::JOB_PIN_LOAD) |-> !pins.low_power_entry_n
      && pins.addr == 21'(new_cfg)) else $error("pin load without low-power pin low");
   a_par_after_hold: assert property (@(posedge clk) disable iff (!rst_n)
      ($rose(par_on_r) && !sw_loaded_r) |-> !pins.low_power_entry_n && $past(cnt_r) >= N_ZZ)
      else $error("partial refresh too early");
   a_dpd_wake_wait: assert property (@(posedge clk) disable iff (!rst_n)
      ($rose(pins.low_power_entry_n) && $past(dpd_on_r)) |-> busy [*8]) else $error("no wake wait");
   a_sw_dpd_refused: assert property (@(posedge clk) disable iff (!rst_n)
      (cmd && wdata[`CMD_SW_LOAD] && !new_cfg[`CFG_SLEEP_BIT]) |=> err_r && !busy)
      else $error("sequence tried to touch deep sleep");
   a_read_keeps_pin: assert property (@(posedge clk) disable iff (!rst_n)
      (op_end && job_r == cfg_access_pkg::JOB_SW_READ) |=> sw_loaded_r == $past(sw_loaded_r))
      else $error("read sequence changed pin behaviour");

   c_sw_load: cover property (@(posedge clk) op_end && job_r == cfg_access_pkg::JOB_SW_LOAD);
   c_sw_read: cover property (@(posedge clk) op_end && job_r == cfg_access_pkg::JOB_SW_READ);
   c_pin_load: cover property (@(posedge clk) op_end && job_r == cfg_access_pkg::JOB_PIN_LOAD);
   c_dpd_exit: cover property (@(posedge clk) state_r == cfg_access_pkg::ST_WAKE);

endmodule // cfg_access_host

`default_nettype wire

// ===== tb/psram_cfg_model.sv
// behavioural model of the memory device: configuration register, sequence decode, sleep modes
// assumes the pins come from a clocked host and settle within 1 ns of its edges
`timescale 1ns/10ps
`default_nettype none

module psram_cfg_model #(
   parameter int          ADDR_W    = 21,
   parameter logic [15:0] ARRAY_TOP = 16'h5a3c
) (
   input  wire logic                      rst_n,
   input  wire cfg_access_pkg::mem_pins_s pins,
   output logic [15:0]                    dq,
   output logic [15:0]                    cfg_value,
   output logic                           par_active,
   output logic                           dpd_active,
   output logic                           viol
);
   localparam logic [20:0] TOP = 21'((64'd1 << ADDR_W) - 1);
   localparam int unsigned N   = 1 << ADDR_W;
   logic [2:0]  hist_r;
   logic [1:0]  cnt_r;
   logic        op_wr, op_top, op_zz, sw_loaded_r, drive, sw_rd, sensor_rate, page_reads;
   logic        zz_long = 1'b0;
   logic [15:0] op_data, op_addr, last_r;
   int unsigned ref_size, ref_lo;
   realtime     t_rise = 0.0;
   realtime     t_fall = 0.0;
   realtime     init_until = 0.0;
   wire         ce_n = pins.ce_n;
   wire         zz_n = pins.low_power_entry_n;

   ////////////////////////////////////////
   initial viol = 1'b0;
   // no sleep before the first pin event; an unknown here would poison every read
   initial dpd_active = 1'b0;
   assign sw_rd = (cnt_r == 2'd3) && (hist_r == 3'b001);
   // reads ignored while in deep sleep or its initialisation
   assign drive = !ce_n && !pins.oe_n && pins.we_n && !dpd_active && ($realtime >= init_until);
   // released bus shows the inverse of the last value, no pull on it
   assign dq = pins.dq_oe ? pins.dq_o : drive ? (sw_rd ? cfg_value : ARRAY_TOP) : ~last_r;

   always @(negedge ce_n) begin
      if (sw_rd && ($realtime - t_rise < 150.0)) viol = 1'b1;
      #1;
      op_wr   = !pins.we_n;
      op_top  = (pins.addr == TOP);
      op_zz   = !zz_n;
      op_data = dq;
      op_addr = pins.addr[15:0];
   end

   always @(posedge ce_n or negedge rst_n) begin
      if (!rst_n) begin
         cfg_value   = 16'h0010;
         sw_loaded_r = 1'b0;
         cnt_r       = 2'd0;
         hist_r      = 3'd0;
      end else begin
         t_rise = $realtime;
         last_r = dq;
         if (op_zz && op_wr) begin
            cfg_value = op_addr;
            cnt_r     = 2'd0;
         end else if (!op_top) begin
            viol  = 1'b1;
            cnt_r = 2'd0;
         end else if (sw_rd) begin
            if (op_wr) begin
               cfg_value   = op_data;
               sw_loaded_r = 1'b1;
            end
            cnt_r = 2'd0;
         end else begin
            hist_r = {hist_r[1:0], op_wr};
            cnt_r  = cnt_r + 2'd1;
         end
      end
   end

   ////////////////////////////////////////
   always @(negedge zz_n) t_fall = $realtime;
   always #100 zz_long = !zz_n && ($realtime - t_fall > 10000.0);
   assign par_active = cfg_value[4] && (sw_loaded_r || zz_long);

   always @(posedge zz_long or posedge zz_n) begin
      if (zz_n) begin
         if (dpd_active) init_until = $realtime + 150000.0;
         dpd_active = 1'b0;
      end else begin
         dpd_active = !cfg_value[4];
      end
   end

   // refresh range and rate decode, kept for inspection only
   assign sensor_rate = (cfg_value[6:5] == 2'b00);
   assign page_reads  = cfg_value[7];
   always_comb begin
      case (cfg_value[1:0])
         2'd1: ref_size = N / 4 * 3;
         2'd2: ref_size = N / 2;
         2'd3: ref_size = N / 4;
         default: ref_size = cfg_value[2] ? 0 : N;
      endcase
      ref_lo = cfg_value[2] ? N - ref_size : 0;
   end
endmodule // psram_cfg_model

`default_nettype wire

// ===== tb/test_psram_config_register_access.sv
// self-checking bench: host controller driving the device model
// assumes the package, the host and the model are compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "cfg_access_defines.svh"

module test_psram_config_register_access;
   localparam logic [4:0]  RA [5] = '{`REG_CFG_VALUE, `REG_STATUS, `REG_READBACK, `REG_TEMP_FLOOR, 5'h14};
   localparam logic [31:0] RV [5] = '{32'h10, 32'h0, 32'h10, 32'h0, 32'h0};
   localparam logic [31:0] RM [5] = '{32'hffffffff, 32'hffffffff, 32'h0000ffff, 32'hffffffff, 32'hffffffff};
   logic                      clk = 1'b0;
   logic                      rst_n = 1'b1;
   logic                      wr, rd, dev_par, dev_dpd, dev_viol;
   logic [4:0]                addr;
   logic [31:0]               wdata, rdata, v, seed;
   logic [15:0]               dq_i, dev_cfg, c;
   cfg_access_pkg::mem_pins_s pins;
   int                        fail_count, checks_done, cycles, n, t;

   cfg_access_host i_cfg_access_host (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
                                      .rd(rd), .rdata(rdata), .pins(pins), .dq_i(dq_i));
   psram_cfg_model i_psram_cfg_model (.rst_n(rst_n), .pins(pins), .dq(dq_i), .cfg_value(dev_cfg),
                                      .par_active(dev_par), .dpd_active(dev_dpd), .viol(dev_viol));

   ////////////////////////////////////////
   always #20 clk = ~clk;
   // ceiling well above the long wake wait plus all sequences
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         fail_count++;
         conclude();
      end
   end

   function automatic logic exp_err(input int code, input int floor);
      return (code != 0) && (code < floor);
   endfunction

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask

   task automatic run(input int bitn, output int waited);
      wr_reg(`REG_CTRL, 32'd1 << bitn);
      waited = 0;
      do begin
         rd_reg(`REG_STATUS, v);
         waited += 2;
      end while (v[1] !== 1'b0 && waited < 8000);
      if (waited >= 8000) check("busy wait", 0, 1);
   endtask

   task automatic conclude;
      $display("checks %0d failures %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////
   initial begin
      seed = 32'h8f93b368;
      {wr, rd, addr, wdata} = '0;
      // late in the time step so the model already waits for the reset edge
      rst_n <= 1'b0;
      {fail_count, checks_done, cycles} = '0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
         rd_reg(RA[i], v);
         check("reset value", RV[i], v & RM[i]);
      end
      check("device power-up", 32'h10, dev_cfg);
      run(`CMD_SW_READ, n);
      rd_reg(`REG_READBACK, v);
      check("sw read value", 32'h10, v[31:16]);
      rd_reg(`REG_STATUS, v);
      check("read keeps pin role", 0, v[3]);
      // partial refresh by the pin, before and after the 10 us limit
      wr_reg(`REG_CTRL, 32'h8);
      repeat (230) @(posedge clk);
      rd_reg(`REG_STATUS, v);
      check("par early", 0, v[4]);
      repeat (30) @(posedge clk);
      rd_reg(`REG_STATUS, v);
      check("par by pin", {31'd0, dev_par}, v[4]);
      run(`CMD_SLEEP_OUT, n);
      rd_reg(`REG_STATUS, v);
      check("par exit", 0, {v[5], v[4], v[0]});
      // deep sleep configured by the pin load
      c = 16'($random(seed)) & 16'h00ef;
      wr_reg(`REG_CFG_VALUE, {16'd0, c});
      run(`CMD_PIN_LOAD, n);
      check("pin load", c, dev_cfg);
      wr_reg(`REG_CTRL, 32'h8);
      repeat (260) @(posedge clk);
      rd_reg(`REG_STATUS, v);
      check("deep sleep by pin", 2'b10, v[5:4]);
      check("device deep sleep", 1, dev_dpd);
      run(`CMD_SLEEP_OUT, n);
      check("wake init", 1, n >= `CYC_INIT - 10 && n <= `CYC_INIT + 20);
      wr_reg(`REG_CFG_VALUE, 32'h10);
      run(`CMD_PIN_LOAD, n);
      // sequence loads across every refresh-rate code against a floor
      wr_reg(`REG_TEMP_FLOOR, 32'd2);
      for (t = 0; t < 6; t++) begin
         c = 16'h0010 | 16'((t & 3) << 5) | (16'($random(seed)) & 16'h0087);
         wr_reg(`REG_CFG_VALUE, {16'd0, c});
         run(`CMD_SW_LOAD, n);
         rd_reg(`REG_STATUS, v);
         check("floor refusal", exp_err(t & 3, 2), v[2]);
         if (!exp_err(t & 3, 2)) begin
            check("sw load value", c, dev_cfg);
            check("par after load", 2'b11, v[4:3]);
            run(`CMD_SW_READ, n);
            rd_reg(`REG_READBACK, v);
            check("sw readback", {c, c}, v);
         end
      end
      c = dev_cfg;
      wr_reg(`REG_CFG_VALUE, 32'h0);
      run(`CMD_SW_LOAD, n);
      rd_reg(`REG_STATUS, v);
      check("deep sleep by sequence", 1, v[2]);
      check("device unchanged", c, dev_cfg);
      c = 16'h0090 | (16'($random(seed)) & 16'h0007);
      wr_reg(`REG_CFG_VALUE, {16'd0, c});
      run(`CMD_PIN_LOAD, n);
      check("pin load after sequence", c, dev_cfg);
      check("host bus discipline", 0, dev_viol);
      conclude();
   end
endmodule // test_psram_config_register_access

`default_nettype wire
